// file: hw/ccpu_pkg.sv
// constants, types and rule summary for the capture/compare/pwm pair
// Contract
// - each unit has one 16-bit register for capture, compare or duty
// - the 16-bit register is reached as low and high bytes
// - both units behave alike except for the special event action; the direction bit and port latch feedback exist for unit one's pin only
// - unit one special event resets the shared wide timer
// - unit two special event resets timer, starts conversion if enabled
// - capture and compare use wide timer; pwm uses period timer
// - two pwm units share period timer frequency and update rate
// - mode selects capture event: fall, rise, every 4th, every 16th rise
// - a capture event copies the wide timer into the value register
// - capture sets the unit flag; it stays until software clears it
// - a new capture overwrites an unread old value
// - a port latch write on an output pin can cause a capture
// - mode 1001 match drives the pin low and sets the flag
// - mode 1010 match sets the flag and leaves the pin alone
// - special event never sets the wide timer overflow flag
// - pwm duty is 10 bits: low byte msbs, control bits 5:4 lsbs
// - clearing control forces the output latch low, not the port latch
// - prescaler counter clears when off, not capturing, or on reset
`default_nettype none
package ccpu_pkg;
    // --------------------------------------------------------------
    // register map (word offsets of the plain register port)
    // --------------------------------------------------------------
    localparam logic [3:0] A_ONE_LOW   = 4'h0;
    localparam logic [3:0] A_ONE_HIGH  = 4'h1;
    localparam logic [3:0] A_ONE_CTRL  = 4'h2;
    localparam logic [3:0] A_TWO_LOW   = 4'h3;
    localparam logic [3:0] A_TWO_HIGH  = 4'h4;
    localparam logic [3:0] A_TWO_CTRL  = 4'h5;
    localparam logic [3:0] A_FLAGS     = 4'h6;
    localparam logic [3:0] A_PIN_CTRL  = 4'h7;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] CTRL_MASK   = 8'h3F;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    // flag register bit positions
    localparam int FLAG_ONE_BIT = 0;
    localparam int FLAG_TWO_BIT = 1;
    // pin control: bit 0 direction unit one (1 input), bit 1 data latch
    localparam int PIN_DIR_BIT  = 0;
    localparam int PIN_DATA_BIT = 1;
    localparam logic [7:0] PIN_CTRL_RESET = 8'h01;
    // mode codes
    localparam logic [3:0] M_OFF      = 4'h0;
    localparam logic [3:0] M_CAP_FALL = 4'h4;
    localparam logic [3:0] M_CAP_RISE = 4'h5;
    localparam logic [3:0] M_CAP_4    = 4'h6;
    localparam logic [3:0] M_CAP_16   = 4'h7;
    localparam logic [3:0] M_CMP_HIGH = 4'h8;
    localparam logic [3:0] M_CMP_LOW  = 4'h9;
    localparam logic [3:0] M_CMP_SOFT = 4'hA;
    localparam logic [3:0] M_CMP_TRIG = 4'hB;
    localparam logic [3:0] PRESC_4_LAST  = 4'h3;
    localparam logic [3:0] PRESC_16_LAST = 4'hF;

    typedef struct packed {
        logic [1:0] duty_lsb;
        logic [3:0] mode;
    } ccpu_ctrl_t;

    typedef struct packed {
        logic        event_pulse;
        logic        trig_pulse;
    } ccpu_evt_t;
endpackage : ccpu_pkg
`default_nettype wire

// file: hw/ccpu_sync.sv
// two-flop synchroniser for one pin level
`default_nettype none
module ccpu_sync (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // level
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_r;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r <= 1'b0;
            q_out  <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule : ccpu_sync
`default_nettype wire

// file: hw/ccpu_unit.sv
// one capture/compare/pwm unit; shared by both instances
`default_nettype none
module ccpu_unit
    import ccpu_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // configuration
    input  wire ccpu_ctrl_t  ctrl_in,
    input  wire logic        ctrl_wr_in,
    input  wire logic        low_wr_in,
    input  wire logic        high_wr_in,
    input  wire logic [7:0]  wdata_in,
    // time bases
    input  wire logic [15:0] wide_timer_in,
    input  wire logic [9:0]  pwm_count_in,
    input  wire logic        period_wrap_in,
    // pin level as seen by the unit
    input  wire logic        pin_in,
    // results
    output logic [15:0]      value_out,
    output logic             out_latch_out,
    output ccpu_evt_t        evt_out
);
    logic [3:0] presc_r;
    logic       pin_d_r;
    logic [1:0] duty_lsb_r;
    logic [1:0] duty_buf_r;
    logic       is_cap;
    logic       is_cmp;
    logic       is_pwm;
    logic       rise;
    logic       fall;
    logic       cap_ev;
    logic       match;
    logic [3:0] presc_last;

    always_comb begin
        is_cap = (ctrl_in.mode[3:2] == 2'b01);
        is_cmp = (ctrl_in.mode[3:2] == 2'b10);
        is_pwm = (ctrl_in.mode[3:2] == 2'b11);
        rise   = pin_in & ~pin_d_r;
        fall   = ~pin_in & pin_d_r;
        presc_last = (ctrl_in.mode == M_CAP_16) ? PRESC_16_LAST
                                                : PRESC_4_LAST;
        cap_ev = 1'b0;
        unique case (ctrl_in.mode)
            M_CAP_FALL: cap_ev = fall;
            M_CAP_RISE: cap_ev = rise;
            M_CAP_4,
            M_CAP_16:   cap_ev = rise && presc_r == presc_last;
            default:    cap_ev = 1'b0;
        endcase
        match = is_cmp && (wide_timer_in == value_out);
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_d_r <= 1'b0;
        end else begin
            pin_d_r <= pin_in;
        end
    end

    // prescaler only counts in the divided capture modes
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            presc_r <= 4'h0;
        end else if (!is_cap || ctrl_wr_in && ctrl_in.mode == M_OFF) begin
            presc_r <= 4'h0;
        end else if (rise && ctrl_in.mode[1]) begin
            presc_r <= (presc_r == presc_last) ? 4'h0 : presc_r + 4'h1;
        end
    end

    // one 16-bit register, byte access; high byte read-only in pwm
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            value_out <= 16'h0000;
        end else if (is_cap && cap_ev) begin
            value_out <= wide_timer_in;
        end else if (is_pwm && period_wrap_in) begin
            value_out[15:8] <= value_out[7:0];
        end else begin
            if (low_wr_in) begin
                value_out[7:0] <= wdata_in;
            end
            if (high_wr_in && !is_pwm) begin
                value_out[15:8] <= wdata_in;
            end
        end
    end

    // two duty lsbs buffered with the high byte at period end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            duty_lsb_r <= 2'b00;
            duty_buf_r <= 2'b00;
        end else begin
            duty_lsb_r <= ctrl_in.duty_lsb;
            if (is_pwm && period_wrap_in) begin
                duty_buf_r <= duty_lsb_r;
            end
        end
    end

    // compare/pwm output latch, separate from port data latch
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            out_latch_out <= 1'b0;
        end else if (ctrl_in.mode == M_OFF) begin
            out_latch_out <= 1'b0;
        end else if (is_pwm) begin
            if (period_wrap_in) begin
                out_latch_out <= ({value_out[7:0], duty_lsb_r} != 10'h000);
            end else if (pwm_count_in == {value_out[15:8], duty_buf_r}) begin
                out_latch_out <= 1'b0;
            end
        end else if (match && ctrl_in.mode == M_CMP_HIGH) begin
            out_latch_out <= 1'b1;
        end else if (match && ctrl_in.mode == M_CMP_LOW) begin
            out_latch_out <= 1'b0;
        end
    end

    // events registered so each match or capture gives one pulse
    logic match_d_r;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            match_d_r   <= 1'b0;
            evt_out     <= '0;
        end else begin
            match_d_r <= match;
            evt_out.event_pulse <= (is_cap && cap_ev)
                                || (match && !match_d_r);
            evt_out.trig_pulse  <= match && !match_d_r
                                && ctrl_in.mode == M_CMP_TRIG;
        end
    end
endmodule : ccpu_unit
`default_nettype wire

// file: hw/ccpu_top.sv
// capture/compare/pwm pair with shared time bases and register port
`default_nettype none
module ccpu_top
    import ccpu_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // register port
    input  wire logic [3:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [7:0]       rdata_out,
    // time bases from the timers
    input  wire logic [15:0] wide_timer_in,
    input  wire logic [9:0]  pwm_count_in,
    input  wire logic        period_wrap_in,
    input  wire logic        adc_enabled_in,
    // pins (output enable low while driving)
    input  wire logic        pin_one_in,
    output logic             pin_one_out,
    output logic             pin_one_oe_n_out,
    input  wire logic        pin_two_in,
    output logic             pin_two_out,
    // events
    output logic             wide_timer_reset_out,
    output logic             adc_start_out,
    output logic             wide_timer_overflow_set_out
);
    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    ccpu_ctrl_t  ctrl_one_r;
    ccpu_ctrl_t  ctrl_two_r;
    logic [1:0]  flags_r;
    logic [7:0]  pin_ctrl_r;
    logic [15:0] val_one;
    logic [15:0] val_two;
    logic        latch_one;
    logic        latch_two;
    ccpu_evt_t   evt_one;
    ccpu_evt_t   evt_two;
    logic        pin_one_s;
    logic        pin_two_s;
    logic        pin_one_lvl;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        hit = wr_in && (a == b);
    endfunction : hit

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_one_r <= CTRL_RESET[5:0];
            ctrl_two_r <= CTRL_RESET[5:0];
        end else begin
            if (hit(addr_in, A_ONE_CTRL)) begin
                ctrl_one_r <= wdata_in[5:0];
            end
            if (hit(addr_in, A_TWO_CTRL)) begin
                ctrl_two_r <= wdata_in[5:0];
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_ctrl_r <= PIN_CTRL_RESET;
        end else if (hit(addr_in, A_PIN_CTRL)) begin
            pin_ctrl_r <= {6'h00, wdata_in[1:0]};
        end
    end

    // flags: hardware set wins over a software clear (write 1 to clear)
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flags_r <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == FLAG_ONE_BIT) ? evt_one.event_pulse
                                        : evt_two.event_pulse) begin
                    flags_r[i] <= 1'b1;
                end else if (hit(addr_in, A_FLAGS) && wdata_in[i]) begin
                    flags_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                A_ONE_LOW:  rdata_out <= val_one[7:0];
                A_ONE_HIGH: rdata_out <= val_one[15:8];
                A_ONE_CTRL: rdata_out <= {2'b00, ctrl_one_r};
                A_TWO_LOW:  rdata_out <= val_two[7:0];
                A_TWO_HIGH: rdata_out <= val_two[15:8];
                A_TWO_CTRL: rdata_out <= {2'b00, ctrl_two_r};
                A_FLAGS:    rdata_out <= {6'h00, flags_r};
                A_PIN_CTRL: rdata_out <= pin_ctrl_r;
                default:    rdata_out <= UNMAPPED_RD;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // --------------------------------------------------------------
    // pins and units
    // --------------------------------------------------------------
    ccpu_sync u_sync_one (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .d_in     (pin_one_in),
        .q_out    (pin_one_s)
    );
    ccpu_sync u_sync_two (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .d_in     (pin_two_in),
        .q_out    (pin_two_s)
    );

    // with the pin an output in capture mode, the port latch feeds back
    always_comb begin
        pin_one_lvl = pin_ctrl_r[PIN_DIR_BIT] ? pin_one_s
                                              : pin_ctrl_r[PIN_DATA_BIT];
    end

    ccpu_unit u_one (
        .clock_in       (clock_in),
        .rst_in         (rst_in),
        .ctrl_in        (ctrl_one_r),
        .ctrl_wr_in     (hit(addr_in, A_ONE_CTRL)),
        .low_wr_in      (hit(addr_in, A_ONE_LOW)),
        .high_wr_in     (hit(addr_in, A_ONE_HIGH)),
        .wdata_in       (wdata_in),
        .wide_timer_in  (wide_timer_in),
        .pwm_count_in   (pwm_count_in),
        .period_wrap_in (period_wrap_in),
        .pin_in         (pin_one_lvl),
        .value_out      (val_one),
        .out_latch_out  (latch_one),
        .evt_out        (evt_one)
    );
    ccpu_unit u_two (
        .clock_in       (clock_in),
        .rst_in         (rst_in),
        .ctrl_in        (ctrl_two_r),
        .ctrl_wr_in     (hit(addr_in, A_TWO_CTRL)),
        .low_wr_in      (hit(addr_in, A_TWO_LOW)),
        .high_wr_in     (hit(addr_in, A_TWO_HIGH)),
        .wdata_in       (wdata_in),
        .wide_timer_in  (wide_timer_in),
        .pwm_count_in   (pwm_count_in),
        .period_wrap_in (period_wrap_in),
        .pin_in         (pin_two_s),
        .value_out      (val_two),
        .out_latch_out  (latch_two),
        .evt_out        (evt_two)
    );

    // compare/pwm modes drive the pin from the output latch
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_one_out      <= 1'b0;
            pin_one_oe_n_out <= 1'b1;
            pin_two_out      <= 1'b0;
        end else begin
            pin_one_out <= ctrl_one_r.mode[3] ? latch_one
                                              : pin_ctrl_r[PIN_DATA_BIT];
            pin_one_oe_n_out <= pin_ctrl_r[PIN_DIR_BIT];
            pin_two_out <= latch_two;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wide_timer_reset_out        <= 1'b0;
            adc_start_out               <= 1'b0;
            wide_timer_overflow_set_out <= 1'b0;
        end else begin
            wide_timer_reset_out <= evt_one.trig_pulse
                                 || evt_two.trig_pulse;
            adc_start_out <= evt_two.trig_pulse && adc_enabled_in;
            wide_timer_overflow_set_out <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    sequence s_trig_two;
        evt_two.trig_pulse && adc_enabled_in;
    endsequence
    AST_TRIG_RESET: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_one.trig_pulse |=> wide_timer_reset_out)
        else $error("special event did not reset timer");
    AST_ADC_START: assert property (@(posedge clock_in) disable iff (rst_in)
        s_trig_two |=> adc_start_out && wide_timer_reset_out)
        else $error("unit two trigger missed conversion start");
    AST_ADC_GATED: assert property (@(posedge clock_in) disable iff (rst_in)
        adc_start_out |-> $past(adc_enabled_in))
        else $error("conversion started with converter off");
    AST_NO_OVF: assert property (@(posedge clock_in) disable iff (rst_in)
        !wide_timer_overflow_set_out)
        else $error("trigger set overflow flag");
    AST_FLAG_SET: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_one.event_pulse |=> flags_r[FLAG_ONE_BIT])
        else $error("event did not set flag");
    AST_FLAG_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
        flags_r[FLAG_ONE_BIT] && !(hit(addr_in, A_FLAGS) && wdata_in[0])
        |=> flags_r[FLAG_ONE_BIT])
        else $error("flag dropped without clear");
    AST_CAPTURE: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(flags_r[FLAG_ONE_BIT]) && ctrl_one_r.mode[3:2] == 2'b01
        && $stable(ctrl_one_r)
        |-> val_one == $past(wide_timer_in, 2))
        else $error("capture value is not the timer");
    AST_OFF_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
        ctrl_one_r.mode == M_OFF ##1 ctrl_one_r.mode == M_OFF
        |-> !latch_one)
        else $error("output latch not low with unit off");
    AST_CTRL_RD: assert property (@(posedge clock_in) disable iff (rst_in)
        rd_in && addr_in == A_ONE_CTRL |=> rdata_out[7:6] == 2'b00)
        else $error("control top bits not zero");
endmodule : ccpu_top
`default_nettype wire

// file: verification/ccpu_pin_src.sv
// event source on the two unit pins, with a selectable response lag
`default_nettype none
module ccpu_pin_src (
    // clock
    input  wire logic       clock_in,
    // requested levels and lag in cycles
    input  wire logic       lvl_one_in,
    input  wire logic       lvl_two_in,
    input  wire logic [2:0] lag_in,
    // device side of the shared pin
    input  wire logic       dev_one_in,
    input  wire logic       dev_one_oe_n_in,
    // pin levels
    output logic            pin_one_out,
    output logic            pin_two_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] h1_r = 8'h00;
    logic [7:0] h2_r = 8'h00;
    always_ff @(posedge clock_in) begin
        h1_r <= {h1_r[6:0], lvl_one_in};
        h2_r <= {h2_r[6:0], lvl_two_in};
    end
    // the source stands off while the device drives the shared pin
    assign pin_one_out = dev_one_oe_n_in ? h1_r[lag_in] : dev_one_in;
    assign pin_two_out = h2_r[lag_in];
endmodule : ccpu_pin_src
`default_nettype wire

// file: verification/ccpu_top_tb_top.sv
// self-checking testbench of the capture/compare/pwm pair
`default_nettype none
module ccpu_top_tb_top
    import ccpu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_in, rst_in, wr_in, rd_in, period_wrap_in;
    logic        adc_enabled_in, pin_one_in, pin_two_in, pin_one_out;
    logic        pin_one_oe_n_out, pin_two_out, wide_timer_reset_out;
    logic        adc_start_out, wide_timer_overflow_set_out;
    logic        lvl_one, lvl_two, pwm_on;
    logic [2:0]  lag;
    logic [3:0]  addr_in;
    logic [7:0]  wdata_in, rdata_out;
    logic [9:0]  pwm_count_in;
    logic [15:0] wide_timer_in;
    int          checks = 0, n_fail = 0, n_trig = 0, n_adc = 0, n_ovf = 0;

    ccpu_top ccpu_top_i (.clock_in, .rst_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .wide_timer_in, .pwm_count_in, .period_wrap_in,
        .adc_enabled_in, .pin_one_in, .pin_one_out, .pin_one_oe_n_out,
        .pin_two_in, .pin_two_out, .wide_timer_reset_out, .adc_start_out,
        .wide_timer_overflow_set_out);
    ccpu_pin_src ccpu_pin_src_i (.clock_in, .lvl_one_in(lvl_one),
        .lvl_two_in(lvl_two), .lag_in(lag), .dev_one_in(pin_one_out),
        .dev_one_oe_n_in(pin_one_oe_n_out), .pin_one_out(pin_one_in),
        .pin_two_out(pin_two_in));

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    // period timer: 64 counts a period, wrap pulse on the last count
    always @(posedge clock_in) begin
        if (pwm_on) begin
            pwm_count_in <= (pwm_count_in == 10'h03F) ? 10'h000
                                                      : pwm_count_in + 10'h001;
            period_wrap_in <= (pwm_count_in == 10'h03E);
        end
        if (wide_timer_reset_out === 1'b1) n_trig++;
        if (adc_start_out === 1'b1) n_adc++;
        if (wide_timer_overflow_set_out !== 1'b0) n_ovf++;
    end
    // ------------------------------------------------------------------
    // register access and comparison
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_reg(input string nm, input logic [3:0] a,
                           input logic [7:0] e);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        chk(nm, {8'h00, e}, {8'h00, rdata_out});
        // return on a rising edge so callers drive inputs there
        @(posedge clock_in);
    endtask : chk_reg
    task automatic pulse(input logic u);
        if (u) lvl_two <= 1'b1;
        else lvl_one <= 1'b1;
        repeat (14) @(posedge clock_in);
        lvl_one <= 1'b0;
        lvl_two <= 1'b0;
        repeat (14) @(posedge clock_in);
    endtask : pulse
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk_reg("ctrl one", A_ONE_CTRL, CTRL_RESET);
        chk_reg("flags", A_FLAGS, 8'h00);
        chk_reg("pin ctrl", A_PIN_CTRL, PIN_CTRL_RESET);
        chk_reg("unmapped", 4'hF, UNMAPPED_RD);
        wr(A_TWO_CTRL, 8'hC4);
        chk_reg("ctrl top bits", A_TWO_CTRL, 8'h04);
        chk("drive enable", 16'h0001, 16'(pin_one_oe_n_out));
        $display("test reset done");
    endtask : t_reset
    // per edges make one capture; n is a multiple of per
    task automatic cap(input logic u, input logic [3:0] m, input int per,
                       input int n, input logic [15:0] t);
        wr(u ? A_TWO_CTRL : A_ONE_CTRL, {4'h0, m});
        wr(A_FLAGS, 8'h03);
        for (int i = 1; i <= n; i++) begin
            wide_timer_in <= t ^ 16'(i);
            pulse(u);
            chk_reg("capture flag", A_FLAGS,
                    {6'h00, u & (i >= per), ~u & (i >= per)});
        end
        chk_reg("value low", u ? A_TWO_LOW : A_ONE_LOW,
                t[7:0] ^ 8'(n));
        chk_reg("value high", u ? A_TWO_HIGH : A_ONE_HIGH, t[15:8]);
        $display("test capture mode %h done", m);
    endtask : cap
    task automatic t_port_cap;
        wr(A_PIN_CTRL, 8'h00);
        wr(A_FLAGS, 8'h03);
        wide_timer_in <= 16'hBEEF;
        wr(A_PIN_CTRL, 8'h02);
        repeat (8) @(posedge clock_in);
        chk_reg("port capture", A_ONE_LOW, 8'hEF);
        chk("drive enable", 16'h0000, 16'(pin_one_oe_n_out));
        wr(A_PIN_CTRL, 8'h01);
        $display("test port capture done");
    endtask : t_port_cap
    task automatic cmp(input logic u, input logic [3:0] m,
                       input logic [15:0] v);
        wide_timer_in <= ~v;
        wr(u ? A_TWO_LOW : A_ONE_LOW, v[7:0]);
        wr(u ? A_TWO_HIGH : A_ONE_HIGH, v[15:8]);
        wr(u ? A_TWO_CTRL : A_ONE_CTRL, {4'h0, m});
        wr(A_FLAGS, 8'h03);
        wide_timer_in <= v;
        repeat (6) @(posedge clock_in);
        wide_timer_in <= ~v;
        if (m != M_CMP_TRIG) begin
            chk_reg("match flag", A_FLAGS, {6'h00, u, ~u});
        end
    endtask : cmp
    task automatic t_compare;
        cmp(1'b0, M_CMP_HIGH, 16'h1234);
        chk("pin set", 16'h0001, 16'(pin_one_out));
        cmp(1'b0, M_CMP_SOFT, 16'h2345);
        chk("pin kept", 16'h0001, 16'(pin_one_out));
        wr(A_ONE_CTRL, 8'h00);
        wr(A_ONE_CTRL, {4'h0, M_CMP_SOFT});
        chk_reg("ctrl one", A_ONE_CTRL, {4'h0, M_CMP_SOFT});
        chk("latch cleared", 16'h0000, 16'(pin_one_out));
        cmp(1'b0, M_CMP_HIGH, 16'h0F0F);
        cmp(1'b0, M_CMP_LOW, 16'hF0F0);
        chk("pin cleared", 16'h0000, 16'(pin_one_out));
        cmp(1'b1, M_CMP_HIGH, 16'h00FF);
        chk("unit two pin", 16'h0001, 16'(pin_two_out));
        $display("test compare done");
    endtask : t_compare
    task automatic t_special;
        int t0;
        int a0;
        for (int k = 0; k < 3; k++) begin
            adc_enabled_in <= (k == 2);
            t0 = n_trig;
            a0 = n_adc;
            cmp(k != 0, M_CMP_TRIG, 16'h4000 + 16'(k));
            chk("timer resets", 16'h0001, 16'(n_trig - t0));
            chk("conversions", 16'(k == 2), 16'(n_adc - a0));
        end
        chk("overflow sets", 16'h0000, 16'(n_ovf));
        $display("test special event done");
    endtask : t_special
    task automatic t_pwm;
        int h1;
        int h2;
        wr(A_ONE_LOW, 8'h03);
        wr(A_ONE_CTRL, 8'h1C);
        wr(A_TWO_LOW, 8'h05);
        wr(A_TWO_CTRL, 8'h0C);
        pwm_on <= 1'b1;
        repeat (140) @(posedge clock_in);
        chk_reg("duty high", A_ONE_HIGH, 8'h03);
        wr(A_ONE_HIGH, 8'hAA);
        chk_reg("duty high kept", A_ONE_HIGH, 8'h03);
        h1 = 0;
        h2 = 0;
        repeat (64) begin
            @(negedge clock_in);
            h1 += int'(pin_one_out === 1'b1);
            h2 += int'(pin_two_out === 1'b1);
        end
        chk("duty step", 16'h0007, 16'(h2 - h1));
        chk("pulse seen", 16'h0001, 16'(h1 > 0 && h1 < 64));
        pwm_on <= 1'b0;
        $display("test pwm done");
    endtask : t_pwm
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clock_in);
        n_fail++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        {rst_in, wr_in, rd_in, period_wrap_in, adc_enabled_in} = 5'h10;
        {lvl_one, lvl_two, pwm_on, lag, addr_in, wdata_in} = 18'h00000;
        pwm_count_in = 10'h000;
        wide_timer_in = 16'h0000;
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset();
        cap(1'b0, M_CAP_RISE, 1, 2, 16'hA5C3);
        t_port_cap();
        lag <= 3'h5;
        cap(1'b1, M_CAP_FALL, 1, 1, 16'h5A3C);
        wr(A_ONE_CTRL, {4'h0, M_CAP_4});
        pulse(1'b0);
        pulse(1'b0);
        wr(A_ONE_CTRL, 8'h00);
        cap(1'b0, M_CAP_4, 4, 4, 16'h1357);
        wr(A_ONE_CTRL, 8'h00);
        cap(1'b0, M_CAP_16, 16, 16, 16'h8642);
        t_compare();
        t_special();
        t_pwm();
        report_and_stop();
    end
endmodule : ccpu_top_tb_top
`default_nettype wire
